//--- core/irbm_pkg.sv
/*
  irbm_pkg: constants shared by the batch-read interrupt monitor block.
  Holds bus widths, register byte offsets, field positions, reset values
  and the layout of the request fields. Assumes a 32-bit plain register
  port with byte addressing and word-aligned registers.
*/
package irbm_pkg;

  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // request field widths
  localparam int EXT_W = 24;       // external channels 8..31
  localparam int EXT_FIRST_CH = 8; // channel shown at bit 0
  localparam int QUAD_W = 6;       // requests per quadrature counter
  localparam int QUAD_N = 3;       // quadrature counter channels
  localparam int TIM_W = 2;        // dual timer requests
  localparam int CTR_W = 20;       // used bits of the counter/timer word

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_EXT_MON = 8'h00;  // external_irq_high_monitor
  localparam logic [ADDR_W-1:0] OFS_CTR_MON = 8'h04;  // counter_timer_irq_monitor
  localparam logic [ADDR_W-1:0] OFS_EXT_STAT = 8'h08; // sticky external events, w1c
  localparam logic [ADDR_W-1:0] OFS_EXT_MASK = 8'h0C; // external event enables
  localparam logic [ADDR_W-1:0] OFS_CTR_STAT = 8'h10; // sticky counter/timer events, w1c
  localparam logic [ADDR_W-1:0] OFS_CTR_MASK = 8'h14; // counter/timer event enables

  // field positions in the external monitor word
  localparam int EXT_LSB = 0;
  localparam int EXT_MSB = 23;

  // field positions in the counter/timer monitor word
  localparam int TIM_LSB = 0;
  localparam int QUAD0_LSB = 2;
  localparam int QUAD1_LSB = 8;
  localparam int QUAD2_LSB = 14;
  localparam int CTR_MSB = 19;

  // bit order inside one quadrature counter group
  localparam int QB_POS_MATCH = 0;  // position match
  localparam int QB_PR_MATCH = 1;   // position-revolution match
  localparam int QB_OUZ = 2;        // overflow/underflow/zero index
  localparam int QB_DIR_REV = 3;    // count direction reversal
  localparam int QB_OUT_RANGE = 4;  // revolution out of range
  localparam int QB_COMB_MATCH = 5; // combined match

  // reset values
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
  localparam logic [EXT_W-1:0] EXT_MASK_RST = 24'h00_0000;
  localparam logic [CTR_W-1:0] CTR_MASK_RST = 20'h0_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL = 32'h0000_0000;

endpackage

//--- core/irbm_edge_bank.sv
/*
  irbm_edge_bank: one sticky event flag per request line.
  A rising edge on a line sets its flag; a one in clr drops it.
  Assumes request lines synchronous to ref_clk and a one-cycle clr.
*/
module irbm_edge_bank #(
  parameter int W = 8
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // request lines and write-one-to-clear vector
  input wire logic [W-1:0] req,
  input wire logic [W-1:0] clr,
  // sticky flags
  output logic [W-1:0] sticky
);

  logic [W-1:0] prev;         // last sampled level of each line
  logic [W-1:0] next_sticky;  // next flag values

  // per bit: the set term wins over a clear in the same cycle
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      next_sticky[i] = (req[i] & ~prev[i]) | (sticky[i] & ~clr[i]);
    end
  end

  // registers only; enable low freezes both edge history and flags
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= '0;
      sticky <= '0;
    end else if (clk_en) begin
      prev <= req;
      sticky <= next_sticky;
    end
  end

endmodule

//--- core/irbm_monitor.sv
/*
  irbm_monitor: batch-read monitor for interrupt vectors 21 and 22, with
  sticky event flags, enable masks and one level interrupt output.
  Assumes all request lines are synchronous to ref_clk, and a register
  master that issues one-cycle strobes, never a read and write together.
*/
// Decided for this implementation: the placing of the registers and the strobed register port.
// How it works
// R1: one word shows all vector-21 requests
// R2: external word bits 31..24 read zero
// R3: bit n shows external channel n+8
// R4: external bit high while request pending
// R5: one word shows all vector-22 requests
// R6: counter/timer word bits 31..20 read zero
// R7: bits 19..14 are quadrature counter 2
// R8: bits 13..8 are quadrature counter 1
// R9: bits 7..2 are quadrature counter 0
// R10: bit1 timer second, bit0 timer first
// R11: quadrature bit high while source requests
// R12: monitor words read-only, reads never clear
module irbm_monitor (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // register port
  input wire logic [irbm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irbm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [irbm_pkg::DATA_W-1:0] reg_rdata,
  // external interrupt channels 8..31, bit 0 is channel 8
  input wire logic [irbm_pkg::EXT_W-1:0] external_request_bits,
  // quadrature counter request groups
  input wire logic [irbm_pkg::QUAD_W-1:0] quad_counter0_requests,
  input wire logic [irbm_pkg::QUAD_W-1:0] quad_counter1_requests,
  input wire logic [irbm_pkg::QUAD_W-1:0] quad_counter2_requests,
  // dual timer requests
  input wire logic dual_timer_first_request,
  input wire logic dual_timer_second_request,
  // interrupt output
  output logic irq
);

  // live monitor words
  logic [irbm_pkg::DATA_W-1:0] ext_mon_word;  // vector 21 view
  logic [irbm_pkg::DATA_W-1:0] ctr_mon_word;  // vector 22 view
  logic [irbm_pkg::CTR_W-1:0] ctr_lines;      // used bits of vector 22

  // address decode
  logic sel_ext_mon;
  logic sel_ctr_mon;
  logic sel_ext_stat;
  logic sel_ext_mask;
  logic sel_ctr_stat;
  logic sel_ctr_mask;

  // event flags and masks
  logic [irbm_pkg::EXT_W-1:0] ext_stat;       // sticky external events
  logic [irbm_pkg::CTR_W-1:0] ctr_stat;       // sticky counter/timer events
  logic [irbm_pkg::EXT_W-1:0] ext_clr;        // w1c vector for ext_stat
  logic [irbm_pkg::CTR_W-1:0] ctr_clr;        // w1c vector for ctr_stat
  logic [irbm_pkg::EXT_W-1:0] ext_mask;
  logic [irbm_pkg::CTR_W-1:0] ctr_mask;
  logic [irbm_pkg::EXT_W-1:0] next_ext_mask;
  logic [irbm_pkg::CTR_W-1:0] next_ctr_mask;

  // read data path
  logic [irbm_pkg::DATA_W-1:0] next_rdata;

  // monitor word assembly; pure wiring so a read shows the present level
  always_comb begin
    ext_mon_word = '0;  // R2
    ext_mon_word[irbm_pkg::EXT_MSB:irbm_pkg::EXT_LSB] = external_request_bits;  // R3 R4
    ctr_lines = {quad_counter2_requests,   // R7 R11
                 quad_counter1_requests,   // R8 R11
                 quad_counter0_requests,   // R9 R11
                 dual_timer_second_request,  // R10
                 dual_timer_first_request};  // R10
    ctr_mon_word = '0;  // R6
    ctr_mon_word[irbm_pkg::CTR_MSB:irbm_pkg::TIM_LSB] = ctr_lines;
  end

  // address decode, shared by reads and writes
  always_comb begin
    sel_ext_mon = (reg_addr == irbm_pkg::OFS_EXT_MON);  // R1
    sel_ctr_mon = (reg_addr == irbm_pkg::OFS_CTR_MON);  // R5
    sel_ext_stat = (reg_addr == irbm_pkg::OFS_EXT_STAT);
    sel_ext_mask = (reg_addr == irbm_pkg::OFS_EXT_MASK);
    sel_ctr_stat = (reg_addr == irbm_pkg::OFS_CTR_STAT);
    sel_ctr_mask = (reg_addr == irbm_pkg::OFS_CTR_MASK);
  end

  // write side: masks load, status bits clear on ones; monitor words have
  // no storage, so a write to them falls through and changes nothing
  always_comb begin
    next_ext_mask = ext_mask;
    next_ctr_mask = ctr_mask;
    ext_clr = '0;
    ctr_clr = '0;
    if (reg_wr) begin
      if (sel_ext_mask) begin
        next_ext_mask = reg_wdata[irbm_pkg::EXT_W-1:0];
      end
      if (sel_ctr_mask) begin
        next_ctr_mask = reg_wdata[irbm_pkg::CTR_W-1:0];
      end
      if (sel_ext_stat) begin
        ext_clr = reg_wdata[irbm_pkg::EXT_W-1:0];
      end
      if (sel_ctr_stat) begin
        ctr_clr = reg_wdata[irbm_pkg::CTR_W-1:0];
      end
    end
  end

  // mask registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_mask <= irbm_pkg::EXT_MASK_RST;
      ctr_mask <= irbm_pkg::CTR_MASK_RST;
    end else if (clk_en) begin
      ext_mask <= next_ext_mask;
      ctr_mask <= next_ctr_mask;
    end
  end

  // rising edges of the external lines become sticky events
  irbm_edge_bank #(
    .W(irbm_pkg::EXT_W)
  ) u_ext_events (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .req(external_request_bits),
    .clr(ext_clr),
    .sticky(ext_stat)
  );

  // rising edges of the counter and timer lines become sticky events
  irbm_edge_bank #(
    .W(irbm_pkg::CTR_W)
  ) u_ctr_events (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .req(ctr_lines),
    .clr(ctr_clr),
    .sticky(ctr_stat)
  );

  // level interrupt: any enabled sticky flag; flops only feed it, so no
  // glitch reaches the output beyond ordinary gate settling
  always_comb begin
    irq = (|(ext_stat & ext_mask)) | (|(ctr_stat & ctr_mask));
  end

  // read mux; a read of a monitor word is a plain sample, nothing clears
  always_comb begin
    next_rdata = irbm_pkg::RDATA_RST;
    if (reg_rd) begin
      unique case (1'b1)
        sel_ext_mon: next_rdata = ext_mon_word;  // R1 R12
        sel_ctr_mon: next_rdata = ctr_mon_word;  // R5 R12
        sel_ext_stat: next_rdata = {{(irbm_pkg::DATA_W-irbm_pkg::EXT_W){1'b0}}, ext_stat};
        sel_ext_mask: next_rdata = {{(irbm_pkg::DATA_W-irbm_pkg::EXT_W){1'b0}}, ext_mask};
        sel_ctr_stat: next_rdata = {{(irbm_pkg::DATA_W-irbm_pkg::CTR_W){1'b0}}, ctr_stat};
        sel_ctr_mask: next_rdata = {{(irbm_pkg::DATA_W-irbm_pkg::CTR_W){1'b0}}, ctr_mask};
        default: next_rdata = irbm_pkg::UNMAPPED_VAL;  // unmapped address
      endcase
    end
  end

  // read data register: valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= irbm_pkg::RDATA_RST;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  ext_mon_read_a: assert property (  // R1
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_EXT_MON)
    |=> reg_rdata[23:0] == $past(external_request_bits))
    else $error("external monitor read mismatch");

  ext_rsvd_zero_a: assert property (  // R2
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_EXT_MON) |=> reg_rdata[31:24] == 8'h00)
    else $error("external monitor reserved bits not zero");

  ext_ch8_bit0_a: assert property (  // R3
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_EXT_MON && external_request_bits[0])
    |=> reg_rdata[0])
    else $error("channel 8 not at bit 0");

  ctr_rsvd_zero_a: assert property (  // R6
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON) |=> reg_rdata[31:20] == 12'h000)
    else $error("counter monitor reserved bits not zero");

  quad2_field_a: assert property (  // R7
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON)
    |=> reg_rdata[19:14] == $past(quad_counter2_requests))
    else $error("quad counter 2 field mismatch");

  quad1_field_a: assert property (  // R8
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON)
    |=> reg_rdata[13:8] == $past(quad_counter1_requests))
    else $error("quad counter 1 field mismatch");

  quad0_field_a: assert property (  // R9
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON)
    |=> reg_rdata[7:2] == $past(quad_counter0_requests))
    else $error("quad counter 0 field mismatch");

  timer_field_a: assert property (  // R10
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON)
    |=> reg_rdata[1:0] == {$past(dual_timer_second_request), $past(dual_timer_first_request)})
    else $error("dual timer field mismatch");

  mon_write_inert_a: assert property (  // R12
    (clk_en && reg_wr && (reg_addr == irbm_pkg::OFS_EXT_MON ||
                          reg_addr == irbm_pkg::OFS_CTR_MON))
    |=> $stable(ext_mask) && $stable(ctr_mask) &&
        (ext_stat & ~$past(ext_stat)) == (ext_stat ^ $past(ext_stat)))
    else $error("monitor write changed state");

  ext_quiet_zero_a: assert property (  // R4
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_EXT_MON && external_request_bits == '0)
    |=> reg_rdata == '0)
    else $error("external monitor not zero with no request");

  // whole counter/timer word, reserved bits included
  ctr_mon_read_a: assert property (  // R5
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON)
    |=> reg_rdata == {12'h000, $past(quad_counter2_requests),
                      $past(quad_counter1_requests), $past(quad_counter0_requests),
                      $past(dual_timer_second_request), $past(dual_timer_first_request)})
    else $error("counter monitor word mismatch");

  quad_comb_bit_a: assert property (  // R11
    (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON &&
     quad_counter0_requests[irbm_pkg::QB_COMB_MATCH])
    |=> reg_rdata[irbm_pkg::QUAD0_LSB + irbm_pkg::QB_COMB_MATCH])
    else $error("quad counter 0 combined match not at its bit");

  // a plain read must clear no event flag that was set
  read_no_clear_a: assert property (  // R12
    (clk_en && reg_rd && (reg_addr == irbm_pkg::OFS_EXT_MON ||
                          reg_addr == irbm_pkg::OFS_CTR_MON))
    |=> (ext_stat & $past(ext_stat)) == $past(ext_stat) &&
        (ctr_stat & $past(ctr_stat)) == $past(ctr_stat))
    else $error("monitor read cleared an event flag");

  // any masked-in rising line raises irq at the next edge, whichever bit it is
  event_sets_irq_a: assert property (
    (clk_en && |(external_request_bits & ~u_ext_events.prev & ext_mask) &&
     !(reg_wr && reg_addr == irbm_pkg::OFS_EXT_MASK))
    |=> irq)
    else $error("enabled event did not raise interrupt");

  // the same for the counter and timer lines
  ctr_event_irq_a: assert property (
    (clk_en && |(ctr_lines & ~u_ctr_events.prev & ctr_mask) &&
     !(reg_wr && reg_addr == irbm_pkg::OFS_CTR_MASK))
    |=> irq)
    else $error("enabled counter event did not raise interrupt");

  // no event pending means no interrupt
  irq_idle_low_a: assert property (
    (ext_stat == '0 && ctr_stat == '0) |-> !irq)
    else $error("interrupt high with no event");

  // a one written to the status word drops that flag when no line rises
  ext_w1c_a: assert property (
    (clk_en && reg_wr && reg_addr == irbm_pkg::OFS_EXT_STAT &&
     !(|(external_request_bits & ~u_ext_events.prev)))
    |=> (ext_stat & $past(reg_wdata[irbm_pkg::EXT_W-1:0])) == '0)
    else $error("status flag survived write-one-to-clear");

  // enable low freezes the answer register
  freeze_hold_a: assert property (
    !clk_en |=> $stable(reg_rdata))
    else $error("read data moved while enable low");

  // the answer stands one cycle; any enabled cycle without a read clears it
  rdata_idle_a: assert property (
    (clk_en && !reg_rd) |=> reg_rdata == '0)
    else $error("read data left standing");

  ext_read_cov: cover property (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_EXT_MON);
  freeze_cov: cover property (!clk_en && reg_rd);
  ctr_irq_cov: cover property (irq && |(ctr_stat & ctr_mask));
  ctr_read_cov: cover property (clk_en && reg_rd && reg_addr == irbm_pkg::OFS_CTR_MON);
  irq_clear_cov: cover property (irq ##1 (clk_en && reg_wr && reg_addr == irbm_pkg::OFS_EXT_STAT)
                                 ##1 !irq);

endmodule

//--- dv/irbm_tb.sv
/*
  tb: self-checking bench for the batch-read interrupt monitor.
  Assumes the register map, field widths and offsets of irbm_pkg and a
  single 40 MHz clock; the bench drives every request line itself.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset, enable (enable low only in the freeze test)
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  // register port, idle at time zero
  logic [irbm_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [irbm_pkg::DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [irbm_pkg::DATA_W-1:0] reg_rdata;
  // request lines, all quiet at time zero
  logic [irbm_pkg::EXT_W-1:0] external_request_bits = '0;
  logic [irbm_pkg::QUAD_W-1:0] quad_counter0_requests = '0;
  logic [irbm_pkg::QUAD_W-1:0] quad_counter1_requests = '0;
  logic [irbm_pkg::QUAD_W-1:0] quad_counter2_requests = '0;
  logic dual_timer_first_request = 1'b0;
  logic dual_timer_second_request = 1'b0;
  logic irq;
  // bookkeeping
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;

  // 25 ns period
  always #12.5 ref_clk = ~ref_clk;

  irbm_monitor uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_request_bits(external_request_bits),
    .quad_counter0_requests(quad_counter0_requests),
    .quad_counter1_requests(quad_counter1_requests),
    .quad_counter2_requests(quad_counter2_requests),
    .dual_timer_first_request(dual_timer_first_request),
    .dual_timer_second_request(dual_timer_second_request), .irq(irq)
  );

  // verdict and end of run, the only exit
  task automatic results();
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one comparison; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [irbm_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe; data is looked at only in the answer cycle
  task automatic rd(input logic [irbm_pkg::ADDR_W-1:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // lines in the counter/timer word layout, split onto the source pins
  task automatic drive(input logic [23:0] e, input logic [19:0] c);
    @(posedge ref_clk);
    external_request_bits <= e;
    dual_timer_first_request <= c[0];
    dual_timer_second_request <= c[1];
    quad_counter0_requests <= c[7:2];
    quad_counter1_requests <= c[13:8];
    quad_counter2_requests <= c[19:14];
  endtask

  // irq is a level, so give the launching edge time to land
  task automatic irq_is(input logic exp);
    @(posedge ref_clk);
    #1;
    chk("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
  endtask

  // hang guard: the tests need well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    // every mapped word and one unmapped word read zero after reset
    for (i = 0; i < 7; i++) begin
      rd(8'(4 * i), 32'h0000_0000, "reset word");
    end
    irq_is(1'b0);
    irq_is(1'b0);
    // walking one over the external channels, bit n is channel n+8
    for (i = 0; i < 24; i++) begin
      drive(24'h00_0001 << i, 20'h0_0000);
      rd(irbm_pkg::OFS_EXT_MON, 32'h0000_0001 << i, "external word");
    end
    // walking one over the counter/timer layout
    for (i = 0; i < 20; i++) begin
      drive(24'h00_0000, 20'h0_0001 << i);
      rd(irbm_pkg::OFS_CTR_MON, 32'h0000_0001 << i, "counter word");
    end
    // all lines high: unused upper bits must still read zero
    drive(24'hFF_FFFF, 20'hF_FFFF);
    rd(irbm_pkg::OFS_EXT_MON, 32'h00FF_FFFF, "external full");
    rd(irbm_pkg::OFS_CTR_MON, 32'h000F_FFFF, "counter full");
    // answer stands one cycle only, so a nonzero word must be gone next cycle
    @(posedge ref_clk);
    #1;
    chk("rdata idle", 32'h0000_0000, reg_rdata);
    // masks are still zero, so no event may reach irq
    irq_is(1'b0);
    // writes to the monitor words change nothing, reads clear nothing
    drive(24'hA5_5A3C, 20'h5_A5C3);
    wr(irbm_pkg::OFS_EXT_MON, 32'h0000_0000);
    wr(irbm_pkg::OFS_CTR_MON, 32'hFFFF_FFFF);
    rd(irbm_pkg::OFS_EXT_MON, 32'h00A5_5A3C, "external kept");
    rd(irbm_pkg::OFS_EXT_MON, 32'h00A5_5A3C, "external reread");
    rd(irbm_pkg::OFS_CTR_MON, 32'h0005_A5C3, "counter kept");
    // enable low: a strobe is ignored and the idle zero answer holds
    @(posedge ref_clk);
    clk_en <= 1'b0;
    rd(irbm_pkg::OFS_EXT_MON, 32'h0000_0000, "frozen read");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    // quiet lines, then clear every sticky flag left by the sweeps
    drive(24'h00_0000, 20'h0_0000);
    wr(irbm_pkg::OFS_EXT_STAT, 32'hFFFF_FFFF);
    wr(irbm_pkg::OFS_CTR_STAT, 32'hFFFF_FFFF);
    rd(irbm_pkg::OFS_EXT_STAT, 32'h0000_0000, "external status");
    rd(irbm_pkg::OFS_CTR_STAT, 32'h0000_0000, "counter status");
    // mask width, then enable external channel 13 alone
    wr(irbm_pkg::OFS_EXT_MASK, 32'hFFFF_FFFF);
    rd(irbm_pkg::OFS_EXT_MASK, 32'h00FF_FFFF, "external mask");
    wr(irbm_pkg::OFS_EXT_MASK, 32'h0000_0020);
    // pulse channels 13 and 14; flags must outlive the pulse
    drive(24'h00_0060, 20'h0_0000);
    drive(24'h00_0000, 20'h0_0000);
    irq_is(1'b1);
    rd(irbm_pkg::OFS_EXT_STAT, 32'h0000_0060, "external sticky");
    // masking hides the event, unmasking brings it back
    wr(irbm_pkg::OFS_EXT_MASK, 32'h0000_0000);
    irq_is(1'b0);
    wr(irbm_pkg::OFS_EXT_MASK, 32'h0000_0020);
    irq_is(1'b1);
    // clearing one flag leaves its neighbour set
    wr(irbm_pkg::OFS_EXT_STAT, 32'h0000_0020);
    irq_is(1'b0);
    rd(irbm_pkg::OFS_EXT_STAT, 32'h0000_0040, "external partial clear");
    // second timer request through the counter/timer event path
    wr(irbm_pkg::OFS_CTR_MASK, 32'hFFFF_FFFF);
    rd(irbm_pkg::OFS_CTR_MASK, 32'h000F_FFFF, "counter mask");
    drive(24'h00_0000, 20'h0_0002);
    drive(24'h00_0000, 20'h0_0000);
    irq_is(1'b1);
    rd(irbm_pkg::OFS_CTR_STAT, 32'h0000_0002, "counter sticky");
    wr(irbm_pkg::OFS_CTR_STAT, 32'h0000_0002);
    irq_is(1'b0);
    results();
  end
endmodule
